/* File: src/crfio_pkg.sv */
package crfio_pkg;

  localparam int REG_COUNT = 32;
  localparam logic [4:0] IMM_BASE = 5'h10;
  localparam logic [15:0] DS_IO_BASE = 16'h0020;
  localparam logic [15:0] DS_IO_LAST = 16'h005F;
  localparam logic [5:0] IO_BIT_LAST = 6'h1F;
  localparam logic [5:0] IO_STATUS_ADDR = 6'h3F;
  localparam int GIE_BIT = 7;
  localparam int COPY_BIT = 6;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int PTR_X_LO = 26;
  localparam int PTR_Y_LO = 28;
  localparam int PTR_Z_LO = 30;

  typedef enum logic [2:0] {
    BIT_NONE = 3'h0,
    BIT_SET = 3'h1,
    BIT_CLEAR = 3'h2,
    BIT_SKIP_ONE = 3'h3,
    BIT_SKIP_ZERO = 3'h4
  } crfio_bitop_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_RMW = 2'h2
  } crfio_state_type;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_REG = 2'h1,
    SRC_STAT = 2'h2,
    SRC_EXT = 2'h3
  } crfio_src_type;

  typedef struct packed {
    logic [4:0] rdAddrA;
    logic rdImmA;
    logic [4:0] rdAddrB;
    logic wrEn;
    logic wrImm;
    logic [4:0] wrAddr;
    logic [7:0] wrData;
  } crfio_regport_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } crfio_dsreq_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
    logic [7:0] wdata;
    crfio_bitop_type bitOp;
    logic [2:0] bitSel;
  } crfio_ioreq_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
    logic [7:0] wdata;
  } crfio_iobus_type;

  typedef struct packed {
    logic irqTaken;
    logic retHandler;
    logic copyToFlag;
    logic copyBit;
  } crfio_statctl_type;

  function automatic logic [4:0] effAddr(input logic [4:0] a, input logic imm);
    return imm ? (IMM_BASE | {1'h0, a[3:0]}) : a;
  endfunction

  function automatic logic dsIsReg(input logic [15:0] a);
    return a < DS_IO_BASE;
  endfunction

  function automatic logic dsIsIo(input logic [15:0] a);
    return (a >= DS_IO_BASE) && (a <= DS_IO_LAST);
  endfunction

  function automatic logic [5:0] ioFromDs(input logic [15:0] a);
    logic [15:0] d;
    d = a - DS_IO_BASE;
    return d[5:0];
  endfunction

  function automatic logic [7:0] bitMod(input logic [7:0] b, input crfio_bitop_type op,
                                        input logic [2:0] sel);
    logic [7:0] r;
    r = b;
    if (op == BIT_SET) begin
      r[sel] = 1'h1;
    end else if (op == BIT_CLEAR) begin
      r[sel] = 1'h0;
    end
    return r;
  endfunction

endpackage

/* File: src/crfio_regmem.sv */
module crfio_regmem (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write port
  input wire logic wrEn,
  input wire logic [4:0] wrAddr,
  input wire logic [7:0] wrData,
  // Read ports
  input wire logic [4:0] rdAddrA,
  input wire logic [4:0] rdAddrB,
  input wire logic [4:0] rdAddrC,
  output logic [7:0] rdDataA,
  output logic [7:0] rdDataB,
  output logic [7:0] rdDataC,
  // Pointer pairs
  output logic [15:0] ptrX,
  output logic [15:0] ptrY,
  output logic [15:0] ptrZ
);

  logic [7:0] mem_r [crfio_pkg::REG_COUNT];
  logic [7:0] mem_nxt [crfio_pkg::REG_COUNT];

  // Reads see the contents before a same-cycle write
  always_comb begin
    mem_nxt = mem_r;
    if (wrEn) begin
      mem_nxt[wrAddr] = wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < crfio_pkg::REG_COUNT; i++) begin
        mem_r[i] <= crfio_pkg::REG_RESET;
      end
      rdDataA <= crfio_pkg::REG_RESET;
      rdDataB <= crfio_pkg::REG_RESET;
      rdDataC <= crfio_pkg::REG_RESET;
      ptrX <= 16'h0000;
      ptrY <= 16'h0000;
      ptrZ <= 16'h0000;
    end else begin
      mem_r <= mem_nxt;
      rdDataA <= mem_r[rdAddrA];
      rdDataB <= mem_r[rdAddrB];
      rdDataC <= mem_r[rdAddrC];
      ptrX <= {mem_r[crfio_pkg::PTR_X_LO + 1], mem_r[crfio_pkg::PTR_X_LO]};
      ptrY <= {mem_r[crfio_pkg::PTR_Y_LO + 1], mem_r[crfio_pkg::PTR_Y_LO]};
      ptrZ <= {mem_r[crfio_pkg::PTR_Z_LO + 1], mem_r[crfio_pkg::PTR_Z_LO]};
    end
  end

endmodule

/* File: src/crfio_status.sv */
module crfio_status (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Software access
  input wire logic swWr,
  input wire logic [7:0] swData,
  // Hardware events
  input crfio_pkg::crfio_statctl_type statCtl,
  // Flags
  output logic [7:0] flags
);

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // Taking an interrupt beats every other update of the enable
  always_comb begin
    flags_nxt = flags_r;
    if (swWr) begin
      flags_nxt = swData;
    end
    if (statCtl.copyToFlag) begin
      flags_nxt[crfio_pkg::COPY_BIT] = statCtl.copyBit;
    end
    if (statCtl.retHandler) begin
      flags_nxt[crfio_pkg::GIE_BIT] = 1'h1;
    end
    if (statCtl.irqTaken) begin
      flags_nxt[crfio_pkg::GIE_BIT] = 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= crfio_pkg::STATUS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

  a_irq_clears_gie: assert property (@(posedge clk) disable iff (rst)
    statCtl.irqTaken |=> !flags_r[crfio_pkg::GIE_BIT])
    else $error("enable still set after interrupt taken");

  a_ret_sets_gie: assert property (@(posedge clk) disable iff (rst)
    statCtl.retHandler && !statCtl.irqTaken |=> flags_r[crfio_pkg::GIE_BIT])
    else $error("enable not set by handler return");

  a_copy_flag_store: assert property (@(posedge clk) disable iff (rst)
    statCtl.copyToFlag |=> flags_r[crfio_pkg::COPY_BIT] == $past(statCtl.copyBit))
    else $error("copy flag does not hold stored bit");

endmodule

/* File: src/crfio_core.sv */
// What this block does
// - Thirty-two working registers are each reachable by any register operation without an immediate operand.
// - Immediate-operand operations select only registers sixteen to thirty-one.
// - Working registers also answer at data addresses zero to thirty-one.
// - Registers twenty-six to thirty-one pair up into three 16-bit pointers.
// - Port-style accesses reach I/O addresses 0x00 to 0x3F and move one byte.
// - A data address equals the I/O address plus 0x20 for I/O registers.
// - Bit set, clear and skip tests work only on I/O addresses 0x00 to 0x1F.
// - Some peripheral flags clear on a written one and ignore a written zero.
// - Bit set and clear rewrite the whole byte, so flags read as one get cleared.
// - The status flags sit at I/O address 0x3F, data address 0x5F.
// - Status bit 7 is the global interrupt enable and blocks all interrupts when zero.
// - Taking an interrupt clears the global enable and handler return sets it.
// - Status bit 6 is the copy flag that bit store writes and bit load reads.
module crfio_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Working register port
  input crfio_pkg::crfio_regport_type regPort,
  output logic [7:0] rdDataA,
  output logic [7:0] rdDataB,
  // Indirect pointers
  output logic [15:0] ptrX,
  output logic [15:0] ptrY,
  output logic [15:0] ptrZ,
  // Data space access
  input crfio_pkg::crfio_dsreq_type dsReq,
  output logic [7:0] dsRdata,
  output logic dsDone,
  // Port-style I/O access
  input crfio_pkg::crfio_ioreq_type ioReq,
  output logic [7:0] ioRdata,
  output logic ioDone,
  output logic skipTaken,
  output logic bitRefused,
  output logic busy,
  // Peripheral register bus
  output crfio_pkg::crfio_iobus_type extIo,
  input wire logic [7:0] extRdata,
  // Status and interrupts
  input crfio_pkg::crfio_statctl_type statCtl,
  input wire logic irqPending,
  output logic [7:0] statusFlags,
  output logic irqAccept
);

  // Unified access of the current cycle
  logic accValid;
  logic accWrite;
  logic accDs;
  logic accIsReg;
  logic accNone;
  logic [4:0] accRegAddr;
  logic [5:0] accIo;
  logic [7:0] accData;
  crfio_pkg::crfio_bitop_type accOp;
  logic accRefuse;
  logic accStatus;
  logic statusWr;

  // Register file hookup
  logic memWrEn;
  logic [4:0] memWrAddr;
  logic [7:0] memWrData;
  logic [7:0] memDataC;

  // Sequencer state
  crfio_pkg::crfio_state_type state_r, state_nxt;
  crfio_pkg::crfio_iobus_type extIo_r, extIo_nxt;
  crfio_pkg::crfio_bitop_type rmwOp_r, rmwOp_nxt;
  logic [2:0] rmwSel_r, rmwSel_nxt;
  logic [5:0] rmwAddr_r, rmwAddr_nxt;
  logic pendValid_r, pendValid_nxt;
  logic pendDs_r, pendDs_nxt;
  logic pendWrite_r, pendWrite_nxt;
  logic pendRefuse_r, pendRefuse_nxt;
  crfio_pkg::crfio_src_type pendSrc_r, pendSrc_nxt;
  logic [7:0] dsRdata_r, dsRdata_nxt;
  logic [7:0] ioRdata_r, ioRdata_nxt;
  logic dsDone_r, dsDone_nxt;
  logic ioDone_r, ioDone_nxt;
  logic skip_r, skip_nxt;
  logic refused_r, refused_nxt;
  logic busy_r, busy_nxt;
  logic irqAccept_r, irqAccept_nxt;
  logic [7:0] rdBack;

  // Port-style requests win over data-space requests in the same cycle
  always_comb begin
    accValid = 1'h0;
    accWrite = 1'h0;
    accDs = 1'h0;
    accIsReg = 1'h0;
    accNone = 1'h0;
    accRegAddr = dsReq.addr[4:0];
    accIo = ioReq.addr;
    accData = ioReq.wdata;
    accOp = crfio_pkg::BIT_NONE;
    if (state_r == crfio_pkg::ST_IDLE) begin
      if (ioReq.valid) begin
        accValid = 1'h1;
        accWrite = ioReq.write;
        accOp = ioReq.bitOp;
      end else if (dsReq.valid) begin
        accValid = 1'h1;
        accDs = 1'h1;
        accWrite = dsReq.write;
        accData = dsReq.wdata;
        if (crfio_pkg::dsIsReg(dsReq.addr)) begin
          accIsReg = 1'h1;
        end else if (crfio_pkg::dsIsIo(dsReq.addr)) begin
          accIo = crfio_pkg::ioFromDs(dsReq.addr);
        end else begin
          accNone = 1'h1;
        end
      end
    end
    accRefuse = (accOp != crfio_pkg::BIT_NONE) && (accIo > crfio_pkg::IO_BIT_LAST);
    accStatus = !accIsReg && !accNone && (accIo == crfio_pkg::IO_STATUS_ADDR);
    statusWr = accValid && accWrite && accStatus && (accOp == crfio_pkg::BIT_NONE);
  end

  // A direct write beats a data-space write to the file; both hit one array
  always_comb begin
    memWrEn = regPort.wrEn || (accValid && accIsReg && accWrite);
    memWrAddr = regPort.wrEn ? crfio_pkg::effAddr(regPort.wrAddr, regPort.wrImm) : accRegAddr;
    memWrData = regPort.wrEn ? regPort.wrData : accData;
  end

  crfio_regmem u_regmem (
    .clk(clk),
    .rst(rst),
    .wrEn(memWrEn),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddrA(crfio_pkg::effAddr(regPort.rdAddrA, regPort.rdImmA)),
    .rdAddrB(regPort.rdAddrB),
    .rdAddrC(accRegAddr),
    .rdDataA(rdDataA),
    .rdDataB(rdDataB),
    .rdDataC(memDataC),
    .ptrX(ptrX),
    .ptrY(ptrY),
    .ptrZ(ptrZ)
  );

  crfio_status u_status (
    .clk(clk),
    .rst(rst),
    .swWr(statusWr),
    .swData(accData),
    .statCtl(statCtl),
    .flags(statusFlags)
  );

  always_comb begin
    case (pendSrc_r)
      crfio_pkg::SRC_REG: rdBack = memDataC;
      crfio_pkg::SRC_STAT: rdBack = statusFlags;
      crfio_pkg::SRC_EXT: rdBack = extRdata;
      default: rdBack = 8'h00;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    extIo_nxt = '0;
    rmwOp_nxt = rmwOp_r;
    rmwSel_nxt = rmwSel_r;
    rmwAddr_nxt = rmwAddr_r;
    pendValid_nxt = 1'h0;
    pendDs_nxt = 1'h0;
    pendWrite_nxt = 1'h0;
    pendRefuse_nxt = 1'h0;
    pendSrc_nxt = crfio_pkg::SRC_NONE;
    dsRdata_nxt = dsRdata_r;
    ioRdata_nxt = ioRdata_r;
    dsDone_nxt = 1'h0;
    ioDone_nxt = 1'h0;
    skip_nxt = 1'h0;
    refused_nxt = 1'h0;
    if (pendValid_r) begin
      if (pendDs_r) begin
        dsDone_nxt = 1'h1;
        if (!pendWrite_r) begin
          dsRdata_nxt = rdBack;
        end
      end else begin
        ioDone_nxt = 1'h1;
        refused_nxt = pendRefuse_r;
        if (!pendWrite_r) begin
          ioRdata_nxt = rdBack;
        end
      end
    end
    case (state_r)
      crfio_pkg::ST_IDLE: begin
        if (accValid && (accOp != crfio_pkg::BIT_NONE) && !accRefuse) begin
          state_nxt = crfio_pkg::ST_RMW;
          extIo_nxt.valid = 1'h1;
          extIo_nxt.addr = accIo;
          rmwOp_nxt = accOp;
          rmwSel_nxt = ioReq.bitSel;
          rmwAddr_nxt = accIo;
        end else if (accValid) begin
          pendValid_nxt = 1'h1;
          pendDs_nxt = accDs;
          pendWrite_nxt = accWrite || accRefuse;
          pendRefuse_nxt = accRefuse;
          if (accIsReg) begin
            pendSrc_nxt = crfio_pkg::SRC_REG;
          end else if (accStatus) begin
            pendSrc_nxt = crfio_pkg::SRC_STAT;
          end else if (!accNone && !accRefuse) begin
            // Written bytes pass unaltered so write-one-to-clear flags behave
            pendSrc_nxt = crfio_pkg::SRC_EXT;
            extIo_nxt.valid = 1'h1;
            extIo_nxt.write = accWrite;
            extIo_nxt.addr = accIo;
            extIo_nxt.wdata = accData;
          end
        end
      end
      crfio_pkg::ST_RMW: begin
        state_nxt = crfio_pkg::ST_IDLE;
        ioDone_nxt = 1'h1;
        ioRdata_nxt = extRdata;
        if (rmwOp_r == crfio_pkg::BIT_SKIP_ONE) begin
          skip_nxt = extRdata[rmwSel_r];
        end else if (rmwOp_r == crfio_pkg::BIT_SKIP_ZERO) begin
          skip_nxt = !extRdata[rmwSel_r];
        end else begin
          // Whole byte goes back, so any flag read as one is cleared too
          extIo_nxt.valid = 1'h1;
          extIo_nxt.write = 1'h1;
          extIo_nxt.addr = rmwAddr_r;
          extIo_nxt.wdata = crfio_pkg::bitMod(extRdata, rmwOp_r, rmwSel_r);
        end
      end
      default: state_nxt = crfio_pkg::ST_IDLE;
    endcase
    busy_nxt = (state_nxt == crfio_pkg::ST_RMW);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= crfio_pkg::ST_IDLE;
      extIo_r <= '0;
      rmwOp_r <= crfio_pkg::BIT_NONE;
      rmwSel_r <= 3'h0;
      rmwAddr_r <= 6'h00;
      pendValid_r <= 1'h0;
      pendDs_r <= 1'h0;
      pendWrite_r <= 1'h0;
      pendRefuse_r <= 1'h0;
      pendSrc_r <= crfio_pkg::SRC_NONE;
      dsRdata_r <= 8'h00;
      ioRdata_r <= 8'h00;
      dsDone_r <= 1'h0;
      ioDone_r <= 1'h0;
      skip_r <= 1'h0;
      refused_r <= 1'h0;
      busy_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      extIo_r <= extIo_nxt;
      rmwOp_r <= rmwOp_nxt;
      rmwSel_r <= rmwSel_nxt;
      rmwAddr_r <= rmwAddr_nxt;
      pendValid_r <= pendValid_nxt;
      pendDs_r <= pendDs_nxt;
      pendWrite_r <= pendWrite_nxt;
      pendRefuse_r <= pendRefuse_nxt;
      pendSrc_r <= pendSrc_nxt;
      dsRdata_r <= dsRdata_nxt;
      ioRdata_r <= ioRdata_nxt;
      dsDone_r <= dsDone_nxt;
      ioDone_r <= ioDone_nxt;
      skip_r <= skip_nxt;
      refused_r <= refused_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Gate is registered, so a clear of the enable stops acceptance next cycle
  always_comb begin
    irqAccept_nxt = irqPending && statusFlags[crfio_pkg::GIE_BIT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqAccept_r <= 1'h0;
    end else begin
      irqAccept_r <= irqAccept_nxt;
    end
  end

  assign extIo = extIo_r;
  assign dsRdata = dsRdata_r;
  assign ioRdata = ioRdata_r;
  assign dsDone = dsDone_r;
  assign ioDone = ioDone_r;
  assign skipTaken = skip_r;
  assign bitRefused = refused_r;
  assign busy = busy_r;
  assign irqAccept = irqAccept_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_rmw_start;
    !busy_r && ioReq.valid && ioReq.addr <= crfio_pkg::IO_BIT_LAST &&
      (ioReq.bitOp == crfio_pkg::BIT_SET || ioReq.bitOp == crfio_pkg::BIT_CLEAR);
  endsequence

  sequence s_rmw_read;
    extIo.valid && !extIo.write;
  endsequence

  a_reg_write_read: assert property (
    regPort.wrEn && !regPort.wrImm ##1 !regPort.rdImmA &&
      regPort.rdAddrA == $past(regPort.wrAddr) && !regPort.wrEn
    |=> rdDataA == $past(regPort.wrData, 2))
    else $error("working register read misses prior write");

  a_imm_upper_half: assert property (
    regPort.wrEn && regPort.wrImm && !regPort.rdImmA ##1
      regPort.rdAddrA == (crfio_pkg::IMM_BASE | $past(regPort.wrAddr)) && !regPort.wrEn
    |=> rdDataA == $past(regPort.wrData, 2))
    else $error("immediate write did not land in upper half");

  a_ds_reg_alias: assert property (
    !busy_r && !ioReq.valid && dsReq.valid && dsReq.write && dsReq.addr < 16'h0020 &&
      !regPort.wrEn ##1 regPort.rdAddrB == $past(dsReq.addr[4:0]) && !regPort.wrEn
    |=> rdDataB == $past(dsReq.wdata, 2))
    else $error("data-space write not seen by register read");

  a_ds_reg_read: assert property (
    !busy_r && !ioReq.valid && dsReq.valid && !dsReq.write && dsReq.addr < 16'h0020
    |=> ##1 dsDone)
    else $error("data-space register read not answered");

  a_ptr_pair: assert property (
    regPort.wrEn && !regPort.wrImm && regPort.wrAddr == 5'h1F
    |=> ##1 ptrZ[15:8] == $past(regPort.wrData, 2))
    else $error("pointer high byte not updated");

  a_port_io_issue: assert property (
    !busy_r && ioReq.valid && ioReq.bitOp == crfio_pkg::BIT_NONE && ioReq.addr != 6'h3F
    |=> extIo.valid && extIo.addr == $past(ioReq.addr) && extIo.write == $past(ioReq.write))
    else $error("port access not forwarded");

  a_io_map_offset: assert property (
    !busy_r && !ioReq.valid && dsReq.valid && dsReq.addr >= 16'h0020 &&
      dsReq.addr < 16'h005F
    |=> extIo.valid && {10'h000, extIo.addr} == $past(dsReq.addr) - 16'h0020)
    else $error("data address not mapped to I/O address");

  a_bit_range: assert property (
    !busy_r && ioReq.valid && ioReq.bitOp != crfio_pkg::BIT_NONE && ioReq.addr > 6'h1F
    |=> !extIo.valid ##1 ioDone && bitRefused)
    else $error("bit operation accepted above bit range");

  a_rmw_writeback: assert property (
    s_rmw_start |=> s_rmw_read ##1 (extIo.valid && extIo.write &&
      extIo.wdata == crfio_pkg::bitMod($past(extRdata), $past(ioReq.bitOp, 2),
                                       $past(ioReq.bitSel, 2))))
    else $error("bit update did not rewrite whole byte");

  a_status_addr: assert property (
    !busy_r && !ioReq.valid && dsReq.valid && dsReq.write && dsReq.addr == 16'h005F &&
      statCtl == '0
    |=> statusFlags == $past(dsReq.wdata) && !extIo.valid)
    else $error("status flags not written at their address");

  a_gie_gate: assert property (
    irqAccept |-> $past(statusFlags[crfio_pkg::GIE_BIT]))
    else $error("interrupt accepted with global enable clear");

endmodule

/* File: verif/crfio_periph_model.sv */
module crfio_periph_model (
  // Clock
  input wire logic clk,
  // Peripheral bus from the block
  input crfio_pkg::crfio_iobus_type extIo,
  output logic [7:0] extRdata,
  // Observation for the bench
  output logic [5:0] lastWrAddr,
  output logic [7:0] lastWrData,
  output logic [7:0] wrCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [64];
  logic [7:0] junk;
  // Outside a read cycle the lines churn, so stale data is never mistaken for an answer
  assign extRdata = (extIo.valid && !extIo.write) ? mem[extIo.addr] : junk;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    junk = 8'h5A;
    lastWrAddr = 6'h00;
    lastWrData = 8'h00;
    wrCount = 8'h00;
  end
  always @(posedge clk) begin
    junk <= junk + 8'h37;
    if (extIo.valid && extIo.write) begin
      mem[extIo.addr] <= extIo.wdata;
      lastWrAddr <= extIo.addr;
      lastWrData <= extIo.wdata;
      wrCount <= wrCount + 8'h01;
    end
  end
endmodule

/* File: verif/tb_cpu_register_file_io_space.sv */
module tb_cpu_register_file_io_space;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  crfio_pkg::crfio_regport_type regPort = '0;
  crfio_pkg::crfio_dsreq_type dsReq = '0;
  crfio_pkg::crfio_ioreq_type ioReq = '0;
  crfio_pkg::crfio_statctl_type statCtl = '0;
  crfio_pkg::crfio_iobus_type extIo;
  logic irqPending = 1'b0;
  logic [7:0] rdDataA, rdDataB, dsRdata, ioRdata, extRdata, statusFlags, lastWrData, wrCount;
  logic [15:0] ptrX, ptrY, ptrZ;
  logic [5:0] lastWrAddr;
  logic dsDone, ioDone, skipTaken, bitRefused, busy, irqAccept;
  logic [7:0] got;
  logic skp, refd, bsy;
  int failCount = 0;
  int checkCount = 0;

  always #2 clk = ~clk;

  crfio_core dut (.clk(clk), .rst(rst), .regPort(regPort), .rdDataA(rdDataA),
    .rdDataB(rdDataB), .ptrX(ptrX), .ptrY(ptrY), .ptrZ(ptrZ), .dsReq(dsReq),
    .dsRdata(dsRdata), .dsDone(dsDone), .ioReq(ioReq), .ioRdata(ioRdata),
    .ioDone(ioDone), .skipTaken(skipTaken), .bitRefused(bitRefused), .busy(busy),
    .extIo(extIo), .extRdata(extRdata), .statCtl(statCtl), .irqPending(irqPending),
    .statusFlags(statusFlags), .irqAccept(irqAccept));

  crfio_periph_model model (.clk(clk), .extIo(extIo), .extRdata(extRdata),
    .lastWrAddr(lastWrAddr), .lastWrData(lastWrData), .wrCount(wrCount));

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    checkCount++;
    if (g !== e) begin
      failCount++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wrapUp;
    if (failCount == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic regWr(input logic [4:0] a, input logic imm, input logic [7:0] d);
    regPort.wrEn = 1'b1;
    regPort.wrImm = imm;
    regPort.wrAddr = a;
    regPort.wrData = d;
    tick;
    regPort.wrEn = 1'b0;
    tick;
  endtask

  task automatic regRd(input logic [4:0] a, input logic imm, input logic [4:0] b);
    regPort.rdAddrA = a;
    regPort.rdImmA = imm;
    regPort.rdAddrB = b;
    tick;
  endtask

  task automatic ds(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    dsReq = '{valid: 1'b1, write: w, addr: a, wdata: d};
    tick;
    dsReq.valid = 1'b0;
    n = 0;
    while (dsDone !== 1'b1 && n < 5) begin
      tick;
      n++;
    end
    chk(dsDone, 1'b1, "data access done");
    got = dsRdata;
    tick;
  endtask

  task automatic io(input logic w, input logic [5:0] a, input logic [7:0] d,
                    input crfio_pkg::crfio_bitop_type op, input logic [2:0] s);
    int n;
    ioReq = '{valid: 1'b1, write: w, addr: a, wdata: d, bitOp: op, bitSel: s};
    tick;
    ioReq.valid = 1'b0;
    bsy = busy;
    n = 0;
    while (ioDone !== 1'b1 && n < 5) begin
      tick;
      n++;
    end
    chk(ioDone, 1'b1, "port access done");
    got = ioRdata;
    skp = skipTaken;
    refd = bitRefused;
    tick;
  endtask

  task automatic strobe(input logic [3:0] v);
    statCtl = v;
    tick;
    statCtl = '0;
    tick;
  endtask

  task automatic tRegs;
    chk(statusFlags, 8'h00, "status after reset");
    // Read address already points at the target so the write-then-read checks fire
    regPort.rdAddrA = 5'h05;
    regWr(5'h05, 1'b0, 8'hA5);
    regPort.rdAddrA = 5'h13;
    regWr(5'h03, 1'b1, 8'h3C);
    regRd(5'h05, 1'b0, 5'h13);
    chk(rdDataA, 8'hA5, "direct register");
    chk(rdDataB, 8'h3C, "immediate write target");
    regRd(5'h03, 1'b1, 5'h03);
    chk(rdDataA, 8'h3C, "immediate read");
    chk(rdDataB, 8'h00, "low register untouched");
  endtask

  task automatic tPtr;
    for (int i = 0; i < 6; i++) begin
      regWr(5'(26 + i), 1'b0, 8'(8'h10 + i));
    end
    tick;
    chk(ptrX, 16'h1110, "pointer X");
    chk(ptrY, 16'h1312, "pointer Y");
    chk(ptrZ, 16'h1514, "pointer Z");
    ds(1'b0, 16'h001F, 8'h00);
    chk(got, 8'h15, "top register by data address");
    regPort.rdAddrB = 5'h1A;
    ds(1'b1, 16'h001A, 8'hEE);
    tick;
    chk(ptrX, 16'h11EE, "pointer after data write");
    ds(1'b1, 16'h0000, 8'h77);
    regRd(5'h00, 1'b0, 5'h1A);
    chk(rdDataA, 8'h77, "register zero by data address");
    chk(rdDataB, 8'hEE, "same storage");
  endtask

  task automatic tIo;
    io(1'b1, 6'h05, 8'h81, crfio_pkg::BIT_NONE, 3'h0);
    chk(bsy, 1'b0, "no busy on plain access");
    chk(lastWrAddr, 6'h05, "port write address");
    chk(lastWrData, 8'h81, "byte forwarded unchanged");
    io(1'b0, 6'h05, 8'h00, crfio_pkg::BIT_NONE, 3'h0);
    chk(got, 8'h81, "port read");
    ds(1'b0, 16'h0025, 8'h00);
    chk(got, 8'h81, "I/O read by data address");
    ds(1'b1, 16'h003E, 8'h42);
    chk(lastWrAddr, 6'h1E, "data address less offset");
    chk(lastWrData, 8'h42, "data write forwarded");
    ds(1'b0, 16'h0060, 8'h00);
    chk(got, 8'h00, "read above data map");
  endtask

  task automatic tBit;
    logic [7:0] n;
    io(1'b1, 6'h03, 8'h81, crfio_pkg::BIT_NONE, 3'h0);
    io(1'b0, 6'h03, 8'h00, crfio_pkg::BIT_SET, 3'h2);
    chk(lastWrData, 8'h85, "set keeps flags read as one");
    chk(bsy, 1'b1, "busy during bit update");
    io(1'b1, 6'h1F, 8'hFF, crfio_pkg::BIT_NONE, 3'h0);
    io(1'b0, 6'h1F, 8'h00, crfio_pkg::BIT_CLEAR, 3'h7);
    chk({lastWrAddr, lastWrData}, {6'h1F, 8'h7F}, "clear at top bit address");
    io(1'b0, 6'h03, 8'h00, crfio_pkg::BIT_SKIP_ONE, 3'h7);
    chk(skp, 1'b1, "skip on one");
    io(1'b0, 6'h03, 8'h00, crfio_pkg::BIT_SKIP_ZERO, 3'h7);
    chk(skp, 1'b0, "no skip on zero test");
    io(1'b0, 6'h03, 8'h00, crfio_pkg::BIT_SKIP_ZERO, 3'h1);
    chk(skp, 1'b1, "skip on zero");
    n = wrCount;
    io(1'b0, 6'h20, 8'h00, crfio_pkg::BIT_SET, 3'h0);
    chk(refd, 1'b1, "bit op above range refused");
    chk(wrCount, n, "no bus write when refused");
  endtask

  task automatic tStat;
    io(1'b1, 6'h3F, 8'h80, crfio_pkg::BIT_NONE, 3'h0);
    chk(statusFlags, 8'h80, "status by port");
    irqPending = 1'b1;
    tick;
    tick;
    chk(irqAccept, 1'b1, "accept when enabled");
    strobe(4'b1000);
    chk(statusFlags[7], 1'b0, "enable cleared on entry");
    chk(irqAccept, 1'b0, "blocked when disabled");
    strobe(4'b0100);
    chk(statusFlags[7], 1'b1, "enable set on return");
    strobe(4'b0011);
    ds(1'b0, 16'h005F, 8'h00);
    chk(got, 8'hC0, "status by data address");
    strobe(4'b0010);
    chk(statusFlags[6], 1'b0, "copy flag stores zero");
    ds(1'b1, 16'h005F, 8'h00);
    tick;
    chk(statusFlags, 8'h00, "status written by data address");
    chk(irqAccept, 1'b0, "no accept after disable");
    irqPending = 1'b0;
  endtask

  initial begin
    #20000;
    failCount++;
    wrapUp;
  end

  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    tick;
    tRegs;
    tPtr;
    tIo;
    tBit;
    tStat;
    wrapUp;
  end
endmodule
